// >>> rtl/dmm_core.sv
// Purpose: internal data memory, dual data pointer, status word and eeprom map
// Assumes: core issues at most one access per port per cycle; reads answer next cycle
// Notes: ram contents are not reset
// What this block does
// - lower 128 bytes at 00h-7Fh reachable by direct and indirect access
// - lowest 32 bytes form 4 banks of 8 working registers
// - two bank-select bits pick bank base 00h, 08h, 10h or 18h
// - 16 bytes above banks hold 128 bits reached by bit address 00h-7Fh
// - upper 128 bytes indirect only; direct 80h-FFh hits special registers
// - 256 bytes expanded ram at 0000h-00FFh via external moves
// - two data pointers share 83h/84h; only the selected one is seen
// - aux bit 0 selects pointer: one second, zero first
// - aux bit 2 always reads zero so increments only toggle select
// - incrementing aux inverts pointer select, result depends on prior state
// - aux bit 5 maps boot flash into F800h-FFFFh when set
// - reset loads boot enable with inverse of bootloader jump bit
// - reset clears aux zero bit, general flag and pointer select
// - reset clears whole status word, selecting bank zero
// - parity flag is one when accumulator has odd count of ones
// - status word carry at bit 7, aux carry bit 6, user flag bit 5
// - overflow flag set by arithmetic signed overflow
// - 2K eeprom at 0000h-07FFh read by external moves when mapped
// - eeprom write: load column latches, then program one row
// - latch bytes carry written flag; only flagged bytes programmed; flags clear
// - eeprom control bit 1 steers external moves to eeprom, else expanded ram
`timescale 1ns/1ps
module dmm_core
  import dmm_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic bootloader_jump_bit,
  input wire logic dir_en,
  input wire logic dir_we,
  input wire logic [7:0] dir_addr,
  input wire logic [7:0] dir_wdata,
  output logic [7:0] dir_rdata,
  input wire logic ind_en,
  input wire logic ind_we,
  input wire logic [7:0] ind_addr,
  input wire logic [7:0] ind_wdata,
  output logic [7:0] ind_rdata,
  input wire logic bit_en,
  input wire logic bit_we,
  input wire logic [6:0] bit_addr,
  input wire logic bit_wdata,
  output logic bit_rdata,
  input wire logic wr_en,
  input wire logic wr_we,
  input wire logic [2:0] wr_idx,
  input wire logic [7:0] wr_wdata,
  output logic [7:0] wr_rdata,
  input wire logic x_en,
  input wire logic x_we,
  input wire logic [7:0] x_wdata,
  output logic [7:0] x_rdata,
  input wire logic data_pointer_inc,
  input wire logic aux_inc,
  input wire logic alu_flags_we,
  input wire logic carry_flag,
  input wire logic aux_carry_flag,
  input wire logic overflow_flag,
  input wire logic [7:0] acc_value,
  input wire logic ee_program,
  output logic [15:0] data_pointer,
  output logic boot_flash_enable,
  output logic [1:0] active_bank
);
  dmm_state_t s_q;
  dmm_state_t s_d;

  function automatic logic [7:0] bank_addr(input logic [7:0] program_status_word, input logic [2:0] idx);
    bank_addr = {3'h0, program_status_word[`DMM_PSW_RS1:`DMM_PSW_RS0], idx};
  endfunction : bank_addr

  function automatic logic [7:0] bit_byte(input logic [6:0] ba);
    bit_byte = `DMM_BITRAM_BASE + {4'h0, ba[6:3]};
  endfunction : bit_byte

  logic [15:0] data_pointer_q;
  logic [7:0] psw_rd;
  logic [7:0] aux_rd;
  assign data_pointer_q = s_q.pointer_select ? s_q.dp1 : s_q.dp0;
  assign psw_rd = {s_q.program_status_word[7:1], ^acc_value};
  assign aux_rd = {2'h0, s_q.boot, 1'b0, s_q.gf3, 1'b0, 1'b0, s_q.pointer_select};

  always_comb begin
    logic [15:0] dp;
    logic [7:0] a;
    dp = 16'h0000;
    a = 8'h00;
    s_d = s_q;
    // status flags from the alu
    if (alu_flags_we) begin
      s_d.program_status_word[`DMM_PSW_CY] = carry_flag;
      s_d.program_status_word[`DMM_PSW_AC] = aux_carry_flag;
      s_d.program_status_word[`DMM_PSW_OV] = overflow_flag;
    end
    if (data_pointer_inc) begin
      if (s_q.pointer_select) begin
        s_d.dp1 = s_q.dp1 + 16'h0001;
      end else begin
        s_d.dp0 = s_q.dp0 + 16'h0001;
      end
    end
    if (aux_inc) begin
      s_d.pointer_select = ~s_q.pointer_select;
    end
    // direct space
    s_d.dir_rd = 8'h00;
    if (dir_en) begin
      if (dir_addr <= `DMM_LOWER_TOP) begin
        s_d.dir_rd = s_q.iram[dir_addr];
        if (dir_we) begin
          s_d.iram[dir_addr] = dir_wdata;
        end
      end else if (dir_addr == `DMM_SFR_DPH) begin
        s_d.dir_rd = data_pointer_q[15:8];
        if (dir_we && s_q.pointer_select) begin
          s_d.dp1[15:8] = dir_wdata;
        end else if (dir_we) begin
          s_d.dp0[15:8] = dir_wdata;
        end
      end else if (dir_addr == `DMM_SFR_DPL) begin
        s_d.dir_rd = data_pointer_q[7:0];
        if (dir_we && s_q.pointer_select) begin
          s_d.dp1[7:0] = dir_wdata;
        end else if (dir_we) begin
          s_d.dp0[7:0] = dir_wdata;
        end
      end else if (dir_addr == `DMM_SFR_AUX) begin
        s_d.dir_rd = aux_rd;
        if (dir_we) begin
          s_d.boot = dir_wdata[`DMM_AUX_BOOT];
          s_d.gf3 = dir_wdata[`DMM_AUX_GF3];
          s_d.pointer_select = dir_wdata[`DMM_AUX_DPS];
        end
      end else if (dir_addr == `DMM_SFR_PSW) begin
        s_d.dir_rd = psw_rd;
        if (dir_we) begin
          s_d.program_status_word[7:1] = dir_wdata[7:1];
        end
      end else if (dir_addr == `DMM_SFR_EEPROM_CONTROL) begin
        s_d.dir_rd = {6'h00, s_q.eee, 1'b0};
        if (dir_we) begin
          s_d.eee = dir_wdata[`DMM_EEC_EEE];
        end
      end
      // other direct addresses above 7Fh leave upper ram untouched
    end
    // indirect space covers all 256 bytes
    s_d.ind_rd = 8'h00;
    if (ind_en) begin
      s_d.ind_rd = s_q.iram[ind_addr];
      if (ind_we) begin
        s_d.iram[ind_addr] = ind_wdata;
      end
    end
    s_d.bit_rd = 1'b0;
    if (bit_en) begin
      a = bit_byte(bit_addr);
      s_d.bit_rd = s_q.iram[a][bit_addr[2:0]];
      if (bit_we) begin
        s_d.iram[a][bit_addr[2:0]] = bit_wdata;
      end
    end
    s_d.wr_rd = 8'h00;
    if (wr_en) begin
      a = bank_addr(s_q.program_status_word, wr_idx);
      s_d.wr_rd = s_q.iram[a];
      if (wr_we) begin
        s_d.iram[a] = wr_wdata;
      end
    end
    // row programming first so a latch write in the same cycle keeps its flag
    if (ee_program) begin
      for (int i = 0; i < `DMM_PAGE_BYTES; i++) begin
        if (s_q.colf[i]) begin
          s_d.eep[{s_q.page, 7'(i)}] = s_q.col[i];
        end
      end
      s_d.colf = '0;
    end
    s_d.x_rd = 8'h00;
    if (x_en) begin
      dp = data_pointer_q;
      if (s_q.eee) begin
        s_d.x_rd = s_q.eep[dp[10:0]];
        if (x_we) begin
          s_d.col[dp[6:0]] = x_wdata;
          s_d.colf[dp[6:0]] = 1'b1;
          s_d.page = dp[10:7];
        end
      end else if (dp[15:8] == 8'h00) begin
        s_d.x_rd = s_q.expanded_ram[dp[7:0]];
        if (x_we) begin
          s_d.expanded_ram[dp[7:0]] = x_wdata;
        end
      end
    end
    if (rst) begin
      s_d.program_status_word = `DMM_PSW_RST;
      s_d.pointer_select = 1'b0;
      s_d.gf3 = 1'b0;
      s_d.boot = ~bootloader_jump_bit;
      s_d.eee = 1'b0;
      s_d.colf = '0;
      s_d.page = 4'h0;
      s_d.dp0 = 16'h0000;
      s_d.dp1 = 16'h0000;
      s_d.dir_rd = 8'h00;
      s_d.ind_rd = 8'h00;
      s_d.bit_rd = 1'b0;
      s_d.wr_rd = 8'h00;
      s_d.x_rd = 8'h00;
    end
  end

  always_ff @(posedge mclk) begin
    s_q <= s_d;
  end

  assign dir_rdata = s_q.dir_rd;
  assign ind_rdata = s_q.ind_rd;
  assign bit_rdata = s_q.bit_rd;
  assign wr_rdata = s_q.wr_rd;
  assign x_rdata = s_q.x_rd;
  assign data_pointer = data_pointer_q;
  assign boot_flash_enable = s_q.boot;
  assign active_bank = s_q.program_status_word[`DMM_PSW_RS1:`DMM_PSW_RS0];

  psw_reset_a: assert property (@(posedge mclk) rst |=> s_q.program_status_word == 8'h00 && active_bank == 2'h0)
    else $error("status word not cleared by reset");
  aux_reset_a: assert property (@(posedge mclk) rst |=> !s_q.pointer_select && !s_q.gf3 && aux_rd[2] == 1'b0)
    else $error("aux control not cleared by reset");
  boot_reset_a: assert property (@(posedge mclk) rst |=> boot_flash_enable == !$past(bootloader_jump_bit))
    else $error("boot enable not inverse of jump bit");
  parity_read_a: assert property (@(posedge mclk) disable iff (rst)
      dir_en && !dir_we && dir_addr == 8'hD0 |=> dir_rdata[0] == ^$past(acc_value))
    else $error("parity flag wrong");
  dps_toggle_a: assert property (@(posedge mclk) disable iff (rst)
      aux_inc && !(dir_en && dir_we && dir_addr == 8'hA2) |=> s_q.pointer_select != $past(s_q.pointer_select))
    else $error("pointer select not toggled");
  aux_zero_a: assert property (@(posedge mclk) disable iff (rst)
      dir_en && dir_addr == 8'hA2 |=> dir_rdata[2] == 1'b0)
    else $error("aux bit 2 not zero");
  bank_read_a: assert property (@(posedge mclk) disable iff (rst)
      wr_en && !wr_we && !ind_en && !dir_en && !bit_en
      |=> wr_rdata == s_q.iram[{3'h0, $past(active_bank), $past(wr_idx)}])
    else $error("working register read wrong byte");
  upper_direct_a: assert property (@(posedge mclk) disable iff (rst)
      dir_en && dir_we && dir_addr[7] && !ind_en && !bit_en && !wr_en
      |=> s_q.iram[$past(dir_addr)] == $past(s_q.iram[dir_addr]))
    else $error("direct access reached upper ram");
  flags_clear_a: assert property (@(posedge mclk) disable iff (rst)
      ee_program && !x_en |=> s_q.colf == '0)
    else $error("latch flags not cleared");
  expanded_ram_steer_a: assert property (@(posedge mclk) disable iff (rst)
      x_en && x_we && !ee_program && !s_q.eee && data_pointer[15:8] == 8'h00
      |=> s_q.expanded_ram[$past(data_pointer[7:0])] == $past(x_wdata) && $stable(s_q.colf))
    else $error("external move not steered to expanded ram");
endmodule : dmm_core

// >>> rtl/dmm_defs.svh
// Purpose: constants of the data memory map block
// Assumes: included by the package only; the module relies on it being compiled first
// Notes: sfr addresses are direct-space byte addresses
`ifndef DMM_DEFS_SVH
`define DMM_DEFS_SVH
`define DMM_SFR_DPH 8'h83
`define DMM_SFR_DPL 8'h84
`define DMM_SFR_AUX 8'hA2
`define DMM_SFR_PSW 8'hD0
`define DMM_SFR_EEPROM_CONTROL 8'hD2
`define DMM_LOWER_TOP 8'h7F
`define DMM_BITRAM_BASE 8'h20
`define DMM_PSW_CY 7
`define DMM_PSW_AC 6
`define DMM_PSW_F0 5
`define DMM_PSW_RS1 4
`define DMM_PSW_RS0 3
`define DMM_PSW_OV 2
`define DMM_PSW_F1 1
`define DMM_PSW_P 0
`define DMM_AUX_BOOT 5
`define DMM_AUX_GF3 3
`define DMM_AUX_ZERO 2
`define DMM_AUX_DPS 0
`define DMM_EEC_EEE 1
`define DMM_PSW_RST 8'h00
`define DMM_IRAM_BYTES 256
`define DMM_EXPANDED_RAM_BYTES 256
`define DMM_EEP_BYTES 2048
`define DMM_PAGE_BYTES 128
`define DMM_PAGES 16
`endif

// >>> rtl/dmm_pkg.sv
// Purpose: types of the data memory map block
// Assumes: sizes come from dmm_defs.svh
// Notes: whole block state is one packed struct
`include "dmm_defs.svh"
package dmm_pkg;
  typedef struct packed {
    logic [`DMM_IRAM_BYTES-1:0][7:0] iram;
    logic [`DMM_EXPANDED_RAM_BYTES-1:0][7:0] expanded_ram;
    logic [`DMM_EEP_BYTES-1:0][7:0] eep;
    logic [`DMM_PAGE_BYTES-1:0][7:0] col;
    logic [`DMM_PAGE_BYTES-1:0] colf;
    logic [3:0] page;
    logic [15:0] dp0;
    logic [15:0] dp1;
    logic [7:0] program_status_word;
    logic boot;
    logic gf3;
    logic pointer_select;
    logic eee;
    logic [7:0] dir_rd;
    logic [7:0] ind_rd;
    logic bit_rd;
    logic [7:0] wr_rd;
    logic [7:0] x_rd;
  } dmm_state_t;
endpackage : dmm_pkg

// >>> tb/data_memory_map_dual_pointer_tb.sv
// Purpose: self-checking bench for the data memory map block
// Assumes: 100 MHz clock, synchronous reset held two cycles
// Notes: core side driven through dmm_cpu_model
`timescale 1ns/1ps
module data_memory_map_dual_pointer_tb;
  logic mclk = 1'b0, rst = 1'b1, bootloader_jump_bit = 1'b1;
  logic dir_en, dir_we, ind_en, ind_we, bit_en, bit_we, bit_wdata, wr_en, wr_we, x_en, x_we;
  logic [7:0] dir_addr, dir_wdata, ind_addr, ind_wdata, wr_wdata, x_wdata, acc_value, r;
  logic [6:0] bit_addr;
  logic [2:0] wr_idx;
  logic data_pointer_inc, aux_inc, alu_flags_we, carry_flag, aux_carry_flag, overflow_flag, ee_program;
  logic [7:0] dir_rdata, ind_rdata, wr_rdata, x_rdata;
  logic bit_rdata, boot_flash_enable;
  logic [15:0] data_pointer;
  logic [1:0] active_bank;
  int n_fail = 0, checks = 0, cyc = 0;
  always #5 mclk = ~mclk;
  dmm_core i_dmm_core (.mclk, .rst, .bootloader_jump_bit, .dir_en, .dir_we, .dir_addr, .dir_wdata, .dir_rdata,
    .ind_en, .ind_we, .ind_addr, .ind_wdata, .ind_rdata, .bit_en, .bit_we, .bit_addr, .bit_wdata, .bit_rdata,
    .wr_en, .wr_we, .wr_idx, .wr_wdata, .wr_rdata, .x_en, .x_we, .x_wdata, .x_rdata, .data_pointer_inc, .aux_inc,
    .alu_flags_we, .carry_flag, .aux_carry_flag, .overflow_flag, .acc_value, .ee_program, .data_pointer,
    .boot_flash_enable, .active_bank);
  dmm_cpu_model i_dmm_cpu_model (.mclk, .dir_en, .dir_we, .ind_en, .ind_we, .bit_en, .bit_we, .bit_wdata,
    .wr_en, .wr_we, .x_en, .x_we, .dir_addr, .dir_wdata, .ind_addr, .ind_wdata, .wr_wdata, .x_wdata,
    .acc_value, .bit_addr, .wr_idx, .data_pointer_inc, .aux_inc, .alu_flags_we, .carry_flag, .aux_carry_flag,
    .overflow_flag, .ee_program, .dir_rdata, .ind_rdata, .wr_rdata, .x_rdata, .bit_rdata);
  task automatic wrap_up;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [15:0] e, g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wt(input int p, input logic [7:0] a, d);
    i_dmm_cpu_model.acc(p, 1'b1, a, d, r);
  endtask : wt
  task automatic rd(input int p, input logic [7:0] a, e, input string nm);
    i_dmm_cpu_model.acc(p, 1'b0, a, 8'h00, r);
    chk(nm, {8'h00, e}, {8'h00, r});
  endtask : rd
  task automatic do_reset(input logic bj);
    @(negedge mclk);
    rst = 1'b1;
    bootloader_jump_bit = bj;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
  endtask : do_reset
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      wrap_up;
    end
  end
  initial begin
    do_reset(1'b1);
    chk("boot enable", 16'h0000, {15'h0000, boot_flash_enable});
    rd(0, 8'hD0, 8'h00, "status");
    rd(0, 8'hA2, 8'h00, "aux");
    // ram is undefined after power-up, so software clears all of it first
    for (int i = 0; i < 256; i++) begin
      wt(1, 8'(i), 8'h00);
    end
    for (int b = 0; b < 4; b++) begin
      wt(0, 8'hD0, 8'(b << 3));
      chk("bank", 16'(b), {14'h0000, active_bank});
      wt(3, 8'h07, 8'hA0 + 8'(b));
      rd(0, 8'(b * 8 + 7), 8'hA0 + 8'(b), "bank byte");
      rd(3, 8'h07, 8'hA0 + 8'(b), "working reg");
      rd(3, 8'(b), 8'h00, "working reg low");
    end
    wt(0, 8'h2F, 8'h00);
    wt(2, 8'h7F, 8'h01);
    rd(0, 8'h2F, 8'h80, "bit byte");
    rd(2, 8'h7F, 8'h01, "bit");
    wt(2, 8'h7F, 8'h00);
    rd(2, 8'h7F, 8'h00, "bit clear");
    wt(2, 8'h00, 8'h01);
    rd(0, 8'h20, 8'h01, "bit zero byte");
    wt(0, 8'h7F, 8'h5A);
    rd(1, 8'h7F, 8'h5A, "lower indirect");
    wt(1, 8'h90, 8'hA5);
    wt(0, 8'h90, 8'hFF);
    rd(1, 8'h90, 8'hA5, "upper indirect");
    rd(0, 8'h90, 8'h00, "upper direct");
    wt(0, 8'h83, 8'h00);
    wt(0, 8'h84, 8'h10);
    wt(4, 8'h00, 8'h3C);
    rd(4, 8'h00, 8'h3C, "expanded_ram");
    wt(0, 8'hA2, 8'h01);
    wt(0, 8'h84, 8'h55);
    chk("pointer one", 16'h0055, data_pointer);
    rd(0, 8'h84, 8'h55, "low byte");
    i_dmm_cpu_model.pulse(1);
    chk("pointer zero", 16'h0010, data_pointer);
    wt(0, 8'hA2, 8'hFF);
    rd(0, 8'hA2, 8'h29, "aux");
    chk("boot", 16'h0001, {15'h0000, boot_flash_enable});
    i_dmm_cpu_model.pulse(1);
    rd(0, 8'hA2, 8'h28, "aux inc");
    i_dmm_cpu_model.alu(8'h07, 1'b1, 1'b0, 1'b1);
    rd(0, 8'hD0, 8'h9D, "flags");
    wt(0, 8'hD0, 8'h20);
    i_dmm_cpu_model.alu(8'h03, 1'b0, 1'b1, 1'b0);
    rd(0, 8'hD0, 8'h60, "aux carry");
    wt(0, 8'hD2, 8'h02);
    rd(0, 8'hD2, 8'h02, "ee control");
    wt(0, 8'h83, 8'h01);
    wt(0, 8'h84, 8'h05);
    wt(4, 8'h00, 8'h77);
    i_dmm_cpu_model.pulse(3);
    wt(0, 8'h84, 8'h85);
    wt(4, 8'h00, 8'h33);
    i_dmm_cpu_model.pulse(3);
    wt(0, 8'h84, 8'h06);
    wt(4, 8'h00, 8'h44);
    i_dmm_cpu_model.pulse(3);
    wt(0, 8'h84, 8'h05);
    rd(4, 8'h00, 8'h77, "eeprom kept");
    wt(0, 8'h84, 8'h85);
    rd(4, 8'h00, 8'h33, "eeprom row");
    wt(0, 8'hD2, 8'h00);
    wt(0, 8'h83, 8'h00);
    wt(0, 8'h84, 8'h10);
    rd(4, 8'h00, 8'h3C, "expanded_ram back");
    wt(0, 8'h83, 8'h01);
    wt(4, 8'h00, 8'hEE);
    rd(4, 8'h00, 8'h00, "expanded_ram refused");
    wt(0, 8'h83, 8'h00);
    i_dmm_cpu_model.pulse(0);
    chk("pointer inc", 16'h0011, data_pointer);
    wt(0, 8'hA2, 8'h01);
    i_dmm_cpu_model.pulse(0);
    chk("pointer one inc", 16'h0056, data_pointer);
    do_reset(1'b0);
    chk("boot enable", 16'h0001, {15'h0000, boot_flash_enable});
    rd(0, 8'hA2, 8'h20, "aux reset");
    rd(0, 8'hD0, 8'h00, "status reset");
    wrap_up;
  end
endmodule : data_memory_map_dual_pointer_tb

// >>> tb/dmm_cpu_model.sv
// Purpose: processor core model that drives the data memory block
// Assumes: requests launched at the falling edge and taken at the next rising edge
// Notes: read data is taken one falling edge after the request
`timescale 1ns/1ps
module dmm_cpu_model (
  input wire logic mclk,
  output logic dir_en,
  output logic dir_we,
  output logic ind_en,
  output logic ind_we,
  output logic bit_en,
  output logic bit_we,
  output logic bit_wdata,
  output logic wr_en,
  output logic wr_we,
  output logic x_en,
  output logic x_we,
  output logic [7:0] dir_addr,
  output logic [7:0] dir_wdata,
  output logic [7:0] ind_addr,
  output logic [7:0] ind_wdata,
  output logic [7:0] wr_wdata,
  output logic [7:0] x_wdata,
  output logic [7:0] acc_value,
  output logic [6:0] bit_addr,
  output logic [2:0] wr_idx,
  output logic data_pointer_inc,
  output logic aux_inc,
  output logic alu_flags_we,
  output logic carry_flag,
  output logic aux_carry_flag,
  output logic overflow_flag,
  output logic ee_program,
  input wire logic [7:0] dir_rdata,
  input wire logic [7:0] ind_rdata,
  input wire logic [7:0] wr_rdata,
  input wire logic [7:0] x_rdata,
  input wire logic bit_rdata
);
  initial begin
    {dir_en, dir_we, ind_en, ind_we, bit_en, bit_we, bit_wdata, wr_en, wr_we, x_en, x_we} = '0;
    {dir_addr, dir_wdata, ind_addr, ind_wdata, wr_wdata, x_wdata, acc_value, bit_addr, wr_idx} = '0;
    {data_pointer_inc, aux_inc, alu_flags_we, carry_flag, aux_carry_flag, overflow_flag, ee_program} = '0;
  end
  // p: 0 direct, 1 indirect, 2 bit, 3 working register, 4 external move
  task automatic acc(input int p, input logic we, input logic [7:0] a, d, output logic [7:0] r);
    @(negedge mclk);
    case (p)
      0: {dir_en, dir_we, dir_addr, dir_wdata} = {1'b1, we, a, d};
      1: {ind_en, ind_we, ind_addr, ind_wdata} = {1'b1, we, a, d};
      2: {bit_en, bit_we, bit_addr, bit_wdata} = {1'b1, we, a[6:0], d[0]};
      3: {wr_en, wr_we, wr_idx, wr_wdata} = {1'b1, we, a[2:0], d};
      default: {x_en, x_we, x_wdata} = {1'b1, we, d};
    endcase
    @(negedge mclk);
    r = (p == 0) ? dir_rdata : (p == 1) ? ind_rdata : (p == 2) ? {7'h00, bit_rdata} : (p == 3) ? wr_rdata : x_rdata;
    {dir_en, ind_en, bit_en, wr_en, x_en} = '0;
  endtask : acc
  // k: 0 pointer increment, 1 aux increment, 3 eeprom program
  task automatic pulse(input int k);
    @(negedge mclk);
    {ee_program, alu_flags_we, aux_inc, data_pointer_inc} = 4'h1 << k;
    @(negedge mclk);
    {ee_program, alu_flags_we, aux_inc, data_pointer_inc} = 4'h0;
  endtask : pulse
  task automatic alu(input logic [7:0] a, input logic c, h, o);
    @(negedge mclk);
    {acc_value, carry_flag, aux_carry_flag, overflow_flag, alu_flags_we} = {a, c, h, o, 1'b1};
    @(negedge mclk);
    alu_flags_we = 1'b0;
  endtask : alu
endmodule : dmm_cpu_model
